/* bench/ifeb_chk.sv */
// Purpose: Port checks of the flag and enable bank.
// Assumes: Read data one cycle after rd_stb.
// Notes:   Flags are seen only through reads and outputs.
`timescale 1ns/1ps
`default_nettype none
module ifeb_chk
  import ifeb_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [ADDR_W-1:0]       addr,
  input wire logic                    wr_stb,
  input wire logic                    rd_stb,
  input wire logic [7:0]              rdata,
  input wire logic [NUM_REG-1:0][7:0] src_evt,
  input wire logic                    core_int_req,
  input wire logic [NUM_GRP-1:0]      group_pending,
  input wire logic                    irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rd_idle_zero: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("rdata not zero outside read");
  a_unmapped_zero: assert property ($past(rd_stb) && $past(addr) == 4'hf
    |-> rdata == 8'h00) else $error("unmapped read not zero");
  a_hole_bits: assert property ($past(rd_stb) && $past(addr) < 4'hd
    |-> (rdata & ~IMPL_MASK[$past(addr)]) == 8'h00)
    else $error("unimplemented bit read as one");
  a_pend_rise: assert property ($rose(group_pending[0])
    |-> $past(wr_stb && addr == 4'h4) || $past(src_evt[4] != 8'h00))
    else $error("group pending rose without cause");
  a_pend_fall: assert property ($fell(group_pending[0])
    |-> $past(wr_stb && addr == 4'h4)) else $error("group flag lost");
  a_core_fall: assert property ($fell(core_int_req)
    |-> $past(wr_stb, 2)) else $error("core request fell by itself");
  a_irq_cause: assert property ($rose(irq)
    |-> core_int_req || $past(wr_stb) || $past(|src_evt))
    else $error("irq rose without cause");
  a_sum_follow: assert property ($past(rd_stb) && $past(addr) == 4'h1
    && $past(group_pending[0], 2) |-> rdata[5])
    else $error("group summary flag not set");
endmodule // ifeb_chk
bind ifeb_bank ifeb_chk u_chk (.clk(clk), .rst(rst), .addr(addr),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .src_evt(src_evt),
  .core_int_req(core_int_req), .group_pending(group_pending), .irq(irq));
`default_nettype wire

/* bench/ifeb_src_model.sv */
// Purpose: Event source model, one-cycle pulses into the bank.
// Assumes: fire is sampled on the rising clock.
// Notes:   Pulses ignore every enable, as real sources do.
`timescale 1ns/1ps
`default_nettype none
module ifeb_src_model
  import ifeb_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [3:0]              idx,
  input  wire logic [2:0]              pos,
  input  wire logic                    fire,
  output logic      [NUM_REG-1:0][7:0] src_evt
);
  localparam logic [NUM_REG*8-1:0] EVT_ONE = {{(NUM_REG*8-1){1'b0}}, 1'b1};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) src_evt <= '0;
    else src_evt <= fire ? (EVT_ONE << {idx, pos}) : '0;
  end
endmodule // ifeb_src_model
`default_nettype wire

/* bench/tb.sv */
// Purpose: Register and event bench of the bank.
// Assumes: Reset held two cycles.
// Notes:   Fixed waits cover the registered core request.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ifeb_pkg::*;
  logic                    clk, rst, wr_stb, rd_stb, fire, core_int_req, irq;
  logic [3:0]              addr, idx;
  logic [2:0]              pos;
  logic [7:0]              wdata, rdata;
  logic [NUM_REG-1:0][7:0] src_evt;
  logic [NUM_GRP-1:0]      group_pending;
  int                      num_errors, samples_checked;
  ifeb_bank uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .src_evt(src_evt),
    .core_int_req(core_int_req), .group_pending(group_pending), .irq(irq));
  ifeb_src_model src (.clk(clk), .rst(rst), .idx(idx), .pos(pos),
    .fire(fire), .src_evt(src_evt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp8(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(logic got, logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  // Idle cycle after each strobe keeps every strobe one cycle long
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    {addr, rd_stb} <= {a, 1'b1};
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 cmp8(rdata, e);
  endtask
  task automatic evt(logic [3:0] i, logic [2:0] p);
    @(posedge clk);
    {idx, pos, fire} <= {i, p, 1'b1};
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    {rst, wr_stb, rd_stb, fire, addr, idx, pos, wdata} = {1'b1, 22'h0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REG; i++) rd(i[3:0], REG_RESET);
    rd(4'hf, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < NUM_REG; i++) wr(i[3:0], 8'hff);
    for (int i = 0; i < NUM_REG; i++) rd(i[3:0], IMPL_MASK[i]);
    for (int i = NUM_REG - 1; i >= 0; i--) wr(i[3:0], 8'h00);
    for (int i = 0; i < NUM_REG; i++) rd(i[3:0], 8'h00);
    $display("test access bits done");
    wr(4'h0, 8'h01);
    evt(4'h1, 3'd7);
    evt(4'h1, 3'd4);
    rd(4'h1, 8'h90);
    cmp1(core_int_req, 1'b0);
    wr(4'h1, 8'h91);
    settle();
    cmp1(core_int_req, 1'b1);
    wr(4'h1, 8'h90);
    settle();
    cmp1(core_int_req, 1'b0);
    wr(4'h1, 8'h98);
    settle();
    cmp1(core_int_req, 1'b1);
    wr(4'h1, 8'h00);
    $display("test direct sources done");
    evt(4'h4, 3'd4);
    rd(4'h4, 8'h10);
    cmp1(group_pending[0], 1'b0);
    wr(4'he, 8'h01);
    wr(4'hd, 8'h03);
    wr(4'h1, 8'h02);
    wr(4'h4, 8'h11);
    settle();
    cmp1(group_pending[0], 1'b1);
    rd(4'h1, 8'h22);
    cmp1(core_int_req, 1'b1);
    cmp1(irq, 1'b1);
    wr(4'hd, 8'h01);
    settle();
    cmp1(irq, 1'b0);
    evt(4'h4, 3'd4);
    rd(4'hd, 8'h02);
    $display("test group source done");
    stop_test();
  end
endmodule // tb
`default_nettype wire

/* rtl/ifeb_bank.sv */
// Purpose: Interrupt request flag and enable register bank.
// Assumes: Event inputs are one-cycle pulses synchronous to clk.
// Notes:   Flags are read/write; a hardware set wins over a software clear.
//
// The address-and-strobe port and the register addresses were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module ifeb_bank
  import ifeb_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output logic      [7:0]                rdata,
  input  wire logic [NUM_REG-1:0][7:0]   src_evt,
  output logic                           core_int_req,
  output logic      [NUM_GRP-1:0]        group_pending,
  output logic                           irq
);

  // ****************************************************************
  // Storage and decode
  // ****************************************************************
  logic [7:0]         bank_r     [NUM_REG];
  logic [7:0]         bank_nxt   [NUM_REG];
  logic [7:0]         sum_set    [NUM_PRI];
  logic [7:0]         hw_set     [NUM_REG];
  logic [NUM_REG-1:0] lost_any;
  logic [NUM_PRI-1:0] pri_hit;
  logic               req_nxt;
  logic               core_req_r;
  logic [EVT_W-1:0]   evt_status_r;
  logic [EVT_W-1:0]   evt_mask_r;
  logic [EVT_W-1:0]   evt_set;
  logic [7:0]         rdata_r;
  logic               wr_status;
  logic               wr_mask;

  assign wr_status = wr_stb && (addr == OFS_BANK_EVT_STATUS);
  assign wr_mask   = wr_stb && (addr == OFS_BANK_EVT_MASK);

  // ****************************************************************
  // Group summaries
  // ****************************************************************
  // A group pends while any of its flags has its enable set
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : g_grp
      assign group_pending[g] =
        |(bank_r[NUM_PRI+g] & FLAG_FIELD &
          (bank_r[NUM_PRI+g] << PAIR_SHIFT));
    end
  endgenerate

  // Level set each cycle keeps the summary flag up while pending
  always_comb begin
    for (int p = 0; p < NUM_PRI; p++) begin
      sum_set[p] = 8'h00;
    end
    for (int n = 0; n < NUM_GRP; n++) begin
      if (group_pending[n]) begin
        sum_set[GRP_SUM_REG[n]][GRP_SUM_BIT[n]] = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register next state
  // ****************************************************************
  genvar r;
  generate
    for (r = 0; r < NUM_REG; r++) begin : g_reg
      logic [7:0] sw_val;
      logic [7:0] direct_mask;
      logic [7:0] sum_bits;

      if (r < NUM_PRI) begin : g_pri
        assign sum_bits = sum_set[r];
      end else begin : g_gp
        assign sum_bits = 8'h00;
      end

      // Summary flag positions are set by group logic, not by events
      assign direct_mask = IMPL_MASK[r] & FLAG_FIELD & ~sum_bits &
                           ((r >= 1 && r < NUM_PRI) ?
                            ~(r == 1 ? 8'h60 : (r == 2 ? 8'hd0 : 8'hf0))
                            : 8'hff);

      assign hw_set[r] = (src_evt[r] & direct_mask) | sum_bits;

      assign sw_val = (wr_stb && (addr == 4'(r))) ? wdata : bank_r[r];

      // Set wins over a clear in the same cycle
      assign bank_nxt[r] = (sw_val | hw_set[r]) & IMPL_MASK[r];

      assign lost_any[r] = |(src_evt[r] & direct_mask & bank_r[r]);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          bank_r[r] <= REG_RESET;
        end else begin
          bank_r[r] <= bank_nxt[r];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Request to the core
  // ****************************************************************
  // Primary flags pair with enables four bits lower, except register 0
  always_comb begin
    for (int p = 0; p < NUM_PRI; p++) begin
      pri_hit[p] = |(bank_r[p] & FLAG_FIELD &
                     (bank_r[p] << ((p == 0) ? PRI0_PAIR_SHIFT
                                              : PAIR_SHIFT)));
    end
    req_nxt = bank_r[0][GLOBAL_INT_ENABLE_BIT] && (|pri_hit);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_req_r <= 1'b0;
    end else begin
      core_req_r <= req_nxt;
    end
  end

  assign core_int_req = core_req_r;

  // ****************************************************************
  // Bank event status, mask and interrupt line
  // ****************************************************************
  assign evt_set[EVT_REQ_RISE]  = req_nxt && !core_req_r;
  assign evt_set[EVT_FLAG_LOST] = |lost_any;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status_r <= '0;
    end else if (wr_status) begin
      evt_status_r <= (evt_status_r & ~wdata[EVT_W-1:0]) | evt_set;
    end else begin
      evt_status_r <= evt_status_r | evt_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_mask_r <= '0;
    end else if (wr_mask) begin
      evt_mask_r <= wdata[EVT_W-1:0];
    end
  end

  assign irq = |(evt_status_r & evt_mask_r);

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rd_stb) begin
      if (addr < 4'(NUM_REG)) begin
        rdata_r <= bank_r[addr];
      end else if (addr == OFS_BANK_EVT_STATUS) begin
        rdata_r <= {{(8-EVT_W){1'b0}}, evt_status_r};
      end else if (addr == OFS_BANK_EVT_MASK) begin
        rdata_r <= {{(8-EVT_W){1'b0}}, evt_mask_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;

endmodule // ifeb_bank

`default_nettype wire

/* rtl/ifeb_pkg.sv */
// Purpose: Constants for the interrupt flag and enable bank.
// Assumes: One 8-bit register per index, reached over a plain port.
// Notes:   Bit layouts below are shared by the bank and its bench.
//
// How it works
// - A source event sets its request flag whether or not it is enabled.
// - Every register carries per-source enable bits that software writes.
// - A flag reads 1 while its request is pending and 0 otherwise; here software can also write a flag to 1, and a set flag holds until written 0.
// - Four primary registers hold global enable, direct and summary pairs.
// - Nine group registers hold the sources folded into each group.
// - Second primary register bit 7 is the serial flag, bit 3 its enable.
// - Its bits 6 and 5 are group 1 and 0 summary flags, bits 2 and 1 enables.
// - Its bit 4 is the request flag of external pin 1.
// - Its bit 0 enables external pin 1 when 1 and disables it when 0.
// - Group summary enables use 1 for enable and 0 for disable.

package ifeb_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned NUM_PRI   = 4;
  localparam int unsigned NUM_GRP   = 9;
  localparam int unsigned NUM_REG   = NUM_PRI + NUM_GRP;
  localparam int unsigned ADDR_W    = 4;

  localparam logic [3:0] OFS_PRIMARY_INT_CTRL_0 = 4'h0;
  localparam logic [3:0] OFS_PRIMARY_INT_CTRL_1 = 4'h1;
  localparam logic [3:0] OFS_PRIMARY_INT_CTRL_2 = 4'h2;
  localparam logic [3:0] OFS_PRIMARY_INT_CTRL_3 = 4'h3;
  localparam logic [3:0] OFS_GROUP_INT_CTRL_0   = 4'h4;
  localparam logic [3:0] OFS_BANK_EVT_STATUS    = 4'hd;
  localparam logic [3:0] OFS_BANK_EVT_MASK      = 4'he;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Implemented bits per register index
  localparam logic [7:0] IMPL_MASK [NUM_REG] = '{
    8'h7f, 8'hff, 8'hff, 8'hff,
    8'h77, 8'hff, 8'h33, 8'h33, 8'h77, 8'hff, 8'hff, 8'hff, 8'h77
  };
  localparam logic [7:0] FLAG_FIELD = 8'hf0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned GLOBAL_INT_ENABLE_BIT = 0;
  localparam int unsigned PRI0_PAIR_SHIFT       = 3;
  localparam int unsigned PAIR_SHIFT            = 4;
  localparam int unsigned SERIAL_IF_FLAG_BIT    = 7;
  localparam int unsigned SERIAL_IF_ENABLE_BIT  = 3;
  localparam int unsigned EXT_PIN1_FLAG_BIT     = 4;
  localparam int unsigned EXT_PIN1_ENABLE_BIT   = 0;

  // Summary flag of group n: primary register and bit
  localparam logic [1:0] GRP_SUM_REG [NUM_GRP] = '{
    2'd1, 2'd1, 2'd2, 2'd2, 2'd2, 2'd3, 2'd3, 2'd3, 2'd3
  };
  localparam logic [2:0] GRP_SUM_BIT [NUM_GRP] = '{
    3'd5, 3'd6, 3'd4, 3'd6, 3'd7, 3'd4, 3'd5, 3'd6, 3'd7
  };

  // Bank event status bits
  localparam int unsigned EVT_REQ_RISE  = 0;
  localparam int unsigned EVT_FLAG_LOST = 1;
  localparam int unsigned EVT_W         = 2;

endpackage : ifeb_pkg
